/* shared/fpk_pkg.sv */
// Contract
// - Show indication one second, then monitor mode
// - Mode key cycles parameter, monitor, alarm; alarm is skipped unless one stands
// - New alarm forces alarm display from any mode but boot
// - Twenty idle seconds return to alarm mode
// - Up/down steps monitor variable, shows its tag
// - Shift steps group, up/down steps number
// - Set enters editing with current value
// - Mode abandons edit without saving
// - Shift moves cursor left, up/down adjust weight
// - Set commits or executes, back to parameters
// - Result code shows about one second
// - Write-protected save refused, read-only code
// - Bad or missing password gives locked code
// - Invalid or reserved value gives range code
// - Servo enabled refuses save, servo-on code
// - Restart parameters store, show power-on code
// - Set in monitor toggles decimal/hex
// - Decimal point marks high or low half in decimal display; hex shows an H or L glyph
// - Alarm shows fixed prefix and three digits
// - Two-second shift hold toggles sign
// - Sign toggle suppressed when out of range
package fpk_pkg;
    localparam int CLK_NS = 8;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int SHOW_MS = 1000;
    localparam int IDLE_MS = 20000;
    localparam int HOLD_MS = 2000;
    localparam int MON_LAST_DEF = 18;
    localparam int GRP_LAST_DEF = 4;
    localparam int CONV_BITS = 32;
    localparam int NKEYS = 5;
    localparam int K_MODE = 0;
    localparam int K_SHIFT = 1;
    localparam int K_UP = 2;
    localparam int K_DOWN = 3;
    localparam int K_SET = 4;
    localparam logic [2:0] CUR_LAST = 3'h4;

    typedef enum logic [2:0] {
        ST_BOOT = 3'h0,
        ST_MON = 3'h1,
        ST_PAR = 3'h3,
        ST_EDIT = 3'h2,
        ST_STAT = 3'h6,
        ST_ALM = 3'h7
    } fpk_state_type;

    typedef enum logic [2:0] {
        SV_SAVED = 3'h0,
        SV_RDONLY = 3'h1,
        SV_LOCKED = 3'h2,
        SV_RANGE = 3'h3,
        SV_SRVON = 3'h4,
        SV_PWRON = 3'h5
    } fpk_status_type;

    // Glyph codes 00..0F are the hex digits
    localparam logic [4:0] G_BLANK = 5'h10;
    localparam logic [4:0] G_L = 5'h11;
    localparam logic [4:0] G_R = 5'h12;
    localparam logic [4:0] G_N = 5'h13;
    localparam logic [4:0] G_O = 5'h14;
    localparam logic [4:0] G_P = 5'h15;
    localparam logic [4:0] G_H = 5'h16;
    localparam logic [4:0] G_DASH = 5'h17;
    localparam logic [4:0] G_U = 5'h18;
    localparam logic [4:0] G_C = 5'h19;
    localparam logic [9:0] ALARM_PREFIX_GLYPHS = {5'h0A, G_L};
    localparam logic [24:0] TXT_SAVED = {5'h05, 5'h0A, G_U, 5'h0E, 5'h0D};
    localparam logic [24:0] TXT_RDONLY = {G_R, G_DASH, G_O, G_N, G_L};
    localparam logic [24:0] TXT_LOCKED = {G_L, G_O, G_C, 5'h0E, 5'h0D};
    localparam logic [24:0] TXT_RANGE = {G_R, 5'h0A, G_N, 5'h06, 5'h0E};
    localparam logic [24:0] TXT_SRVON = {5'h05, G_R, G_U, G_O, G_N};
    localparam logic [24:0] TXT_PWRON = {G_P, G_O, G_DASH, G_O, G_N};

    function automatic logic [4:0] fpk_hex(input logic [3:0] n);
        return {1'b0, n};
    endfunction

    function automatic logic [24:0] fpk_bcd5(input logic [19:0] b);
        return {fpk_hex(b[19:16]), fpk_hex(b[15:12]), fpk_hex(b[11:8]), fpk_hex(b[7:4]), fpk_hex(b[3:0])};
    endfunction

    function automatic logic [31:0] fpk_pow10(input logic [2:0] k);
        case (k)
            3'h1: return 32'hA;
            3'h2: return 32'h64;
            3'h3: return 32'h3E8;
            3'h4: return 32'h2710;
            default: return 32'h1;
        endcase
    endfunction

    // Segments gfedcba
    function automatic logic [6:0] fpk_seg(input logic [4:0] g);
        case (g)
            5'h00: return 7'h3F;
            5'h01: return 7'h06;
            5'h02: return 7'h5B;
            5'h03: return 7'h4F;
            5'h04: return 7'h66;
            5'h05: return 7'h6D;
            5'h06: return 7'h7D;
            5'h07: return 7'h07;
            5'h08: return 7'h7F;
            5'h09: return 7'h6F;
            5'h0A: return 7'h77;
            5'h0B: return 7'h7C;
            5'h0C: return 7'h39;
            5'h0D: return 7'h5E;
            5'h0E: return 7'h79;
            5'h0F: return 7'h71;
            5'h11: return 7'h38;
            5'h12: return 7'h50;
            5'h13: return 7'h54;
            5'h14: return 7'h5C;
            5'h15: return 7'h73;
            5'h16: return 7'h74;
            5'h17: return 7'h40;
            5'h18: return 7'h1C;
            5'h19: return 7'h58;
            default: return 7'h00;
        endcase
    endfunction
endpackage

/* shared/fpk_conv_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fpk_conv_if;
    logic start;
    logic busy;
    logic done;
    logic [31:0] bin;
    logic [39:0] bcd;
    modport conv(input start, input bin, output busy, output done, output bcd);
    modport user(output start, output bin, input busy, input done, input bcd);
endinterface
`default_nettype wire

/* src/fpk_bcd_conv.sv */
`timescale 1ns/1ps
`default_nettype none
module fpk_bcd_conv
    import fpk_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    fpk_conv_if.conv cv
);
    logic [31:0] sh_q;
    logic [39:0] acc_q;
    logic [39:0] bcd_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [39:0] dab;

    function automatic logic [39:0] dabble(input logic [39:0] a);
        logic [39:0] r;
        r = a;
        for (int i = 0; i < 10; i++) begin
            if (r[i*4+:4] >= 4'h5) r[i*4+:4] = r[i*4+:4] + 4'h3;
        end
        return r;
    endfunction

    assign dab = dabble(acc_q);
    assign cv.busy = busy_q;
    assign cv.done = done_q;
    assign cv.bcd = bcd_q;

    // Shift-and-add-3, one input bit per cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_q <= 32'h0;
            acc_q <= 40'h0;
            bcd_q <= 40'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && cv.start) begin
                sh_q <= cv.bin;
                acc_q <= 40'h0;
                cnt_q <= 6'(CONV_BITS);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                acc_q <= {dab[38:0], sh_q[31]};
                sh_q <= {sh_q[30:0], 1'b0};
                cnt_q <= cnt_q - 6'h1;
                if (cnt_q == 6'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    bcd_q <= {dab[38:0], sh_q[31]};
                end
            end
        end
    end

    AST_CONV_LEN: assert property (@(posedge mclk) disable iff (sys_rst)
        (!busy_q && cv.start) |-> ##33 done_q)
        else $error("conversion did not finish in 33 cycles");
endmodule
`default_nettype wire

/* src/fpk_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module fpk_panel
    import fpk_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int SHOW_T = SHOW_MS,
    parameter int IDLE_T = IDLE_MS,
    parameter int HOLD_T = HOLD_MS,
    parameter int MON_LAST = MON_LAST_DEF,
    parameter int GRP_LAST = GRP_LAST_DEF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NKEYS-1:0] key_raw,
    input wire logic alarm_active,
    input wire logic alarm_new,
    input wire logic [11:0] alarm_code,
    input wire logic [31:0] mon_value,
    input wire logic mon_wide,
    input wire logic [31:0] par_value,
    input wire logic [31:0] par_min,
    input wire logic [31:0] par_max,
    input wire logic par_ro,
    input wire logic par_locked,
    input wire logic par_reserved,
    input wire logic par_restart,
    input wire logic par_is_cmd,
    input wire logic servo_on,
    output logic [4:0] mon_sel,
    output logic [3:0] grp_sel,
    output logic [6:0] par_num,
    output logic par_wr_en,
    output logic [31:0] par_wr_value,
    output logic cmd_exec,
    output logic [34:0] seg_out,
    output logic [4:0] dp_out,
    output logic [4:0] blink_out,
    output logic [2:0] ui_mode
);
    if (TICK_CYC < 2 || SHOW_T < 2 || IDLE_T < 2 || HOLD_T < 2 || SHOW_T > 65535 ||
        IDLE_T > 65535 || HOLD_T > 65535 || MON_LAST > 31 || MON_LAST < 1 ||
        GRP_LAST > 15 || GRP_LAST < 1) begin : g_bad
        $error("fpk_panel: parameter out of range");
    end

    localparam int TW = $clog2(TICK_CYC);

    fpk_state_type st_q;
    fpk_state_type st_d;
    fpk_status_type stat_q;
    fpk_status_type stat_d;
    logic [TW-1:0] div_q;
    logic tick;
    logic [NKEYS-1:0] samp_q;
    logic [NKEYS-1:0] db_q;
    logic [NKEYS-1:0] db_d;
    logic [NKEYS-1:0] rise;
    logic [15:0] hold_q;
    logic long_q;
    logic ev_mode;
    logic ev_shift;
    logic ev_long;
    logic ev_up;
    logic ev_dn;
    logic ev_set;
    logic any_key;
    logic [15:0] show_q;
    logic show_on;
    logic show_end;
    logic show_load;
    logic [15:0] idle_q;
    logic idle_run;
    logic idle_hit;
    logic [4:0] mon_sel_q;
    logic hex_q;
    logic half_q;
    logic [3:0] grp_q;
    logic [6:0] num_q;
    logic [3:0] num_tens;
    logic [3:0] num_ones;
    logic [31:0] edit_q;
    logic [2:0] cur_q;
    logic [31:0] flip;
    logic flip_ok;
    logic out_rng;
    logic accept;
    logic commit;
    logic par_wr_en_q;
    logic cmd_exec_q;
    logic [31:0] par_wr_value_q;
    logic [31:0] src;
    logic neg;
    logic [31:0] mag;
    logic [15:0] hw;
    logic [24:0] tag_g;
    logic [24:0] mon_hex_g;
    logic [24:0] mon_dec_g;
    logic [24:0] par_g;
    logic [24:0] alm_g;
    logic [24:0] stat_g;
    logic [24:0] disp_g;
    logic dec_show;
    logic wide_dec;
    logic [4:0] dp_d;
    logic [4:0] blink_d;
    logic [34:0] seg_q;
    logic [4:0] dp_q;
    logic [4:0] blink_q;

    fpk_conv_if cv();

    fpk_bcd_conv u_conv (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cv(cv.conv)
    );

    // Millisecond enable
    assign tick = (div_q == TW'(TICK_CYC - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) div_q <= '0;
        else div_q <= tick ? '0 : div_q + TW'(1);
    end

    // A key level changes only after two agreeing samples
    assign db_d = (key_raw & samp_q) | (db_q & (key_raw | samp_q));
    assign rise = tick ? (db_d & ~db_q) : '0;
    assign ev_mode = rise[K_MODE];
    assign ev_up = rise[K_UP];
    assign ev_dn = rise[K_DOWN];
    assign ev_set = rise[K_SET];
    assign ev_long = tick & db_q[K_SHIFT] & db_d[K_SHIFT] & ~long_q & (hold_q == 16'(HOLD_T - 1));
    assign ev_shift = tick & db_q[K_SHIFT] & ~db_d[K_SHIFT] & ~long_q;
    assign any_key = (|rise) | ev_shift | ev_long;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            samp_q <= '0;
            db_q <= '0;
        end else if (tick) begin
            samp_q <= key_raw;
            db_q <= db_d;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= 16'h0;
            long_q <= 1'b0;
        end else if (rise[K_SHIFT]) begin
            hold_q <= 16'h0;
            long_q <= 1'b0;
        end else if (ev_long) begin
            long_q <= 1'b1;
        end else if (tick && db_q[K_SHIFT] && !long_q) begin
            hold_q <= hold_q + 16'h1;
        end
    end

    // One-second display hold for boot, monitor tag and result code
    assign show_on = (show_q != 16'h0);
    assign show_end = tick && (show_q == 16'h1);
    assign show_load = (st_q == ST_MON && st_d == ST_MON && (ev_up || ev_dn)) ||
        (st_q != ST_STAT && st_d == ST_STAT);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) show_q <= 16'(SHOW_T);
        else if (show_load) show_q <= 16'(SHOW_T);
        else if (tick && show_on) show_q <= show_q - 16'h1;
    end

    // Inactivity count only matters while an alarm stands
    assign idle_run = alarm_active && st_q != ST_ALM && st_q != ST_BOOT;
    assign idle_hit = idle_run && !any_key && tick && (idle_q == 16'(IDLE_T - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) idle_q <= 16'h0;
        else if (!idle_run || any_key) idle_q <= 16'h0;
        else if (tick) idle_q <= idle_q + 16'h1;
    end

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_BOOT: if (show_end) st_d = ST_MON;
            ST_MON: if (ev_mode) st_d = alarm_active ? ST_ALM : ST_PAR;
            ST_PAR: begin
                if (ev_mode) st_d = ST_MON;
                else if (ev_set) st_d = ST_EDIT;
            end
            ST_EDIT: begin
                if (ev_mode) st_d = ST_PAR;
                else if (ev_set) st_d = ST_STAT;
            end
            ST_STAT: if (show_end) st_d = ST_PAR;
            ST_ALM: if (ev_mode) st_d = ST_PAR;
            default: st_d = ST_BOOT;
        endcase
        if (st_q != ST_BOOT && (alarm_new || idle_hit)) st_d = ST_ALM;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) st_q <= ST_BOOT;
        else st_q <= st_d;
    end

    // Save checks, first refusal wins
    assign out_rng = par_reserved || ($signed(edit_q) < $signed(par_min)) ||
        ($signed(edit_q) > $signed(par_max));
    assign stat_d = par_ro ? SV_RDONLY :
        par_locked ? SV_LOCKED :
        servo_on ? SV_SRVON :
        out_rng ? SV_RANGE :
        par_restart ? SV_PWRON : SV_SAVED;
    assign accept = !(par_ro || par_locked || servo_on || out_rng);
    assign commit = (st_q == ST_EDIT) && (st_d == ST_STAT);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= SV_SAVED;
            par_wr_en_q <= 1'b0;
            cmd_exec_q <= 1'b0;
            par_wr_value_q <= 32'h0;
        end else begin
            par_wr_en_q <= commit && accept && !par_is_cmd;
            cmd_exec_q <= commit && accept && par_is_cmd;
            if (commit) begin
                stat_q <= stat_d;
                par_wr_value_q <= edit_q;
            end
        end
    end

    // Monitor and parameter selection
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_sel_q <= 5'h0;
            hex_q <= 1'b0;
            half_q <= 1'b0;
            grp_q <= 4'h0;
            num_q <= 7'h0;
        end else if (st_q == ST_MON && st_d == ST_MON) begin
            if (ev_up) mon_sel_q <= (mon_sel_q == 5'(MON_LAST)) ? 5'h0 : mon_sel_q + 5'h1;
            else if (ev_dn) mon_sel_q <= (mon_sel_q == 5'h0) ? 5'(MON_LAST) : mon_sel_q - 5'h1;
            else if (ev_set) hex_q <= !hex_q;
            else if (ev_shift) half_q <= !half_q;
        end else if (st_q == ST_PAR && st_d == ST_PAR) begin
            if (ev_shift) grp_q <= (grp_q == 4'(GRP_LAST)) ? 4'h0 : grp_q + 4'h1;
            else if (ev_up) num_q <= (num_q == 7'h63) ? 7'h0 : num_q + 7'h1;
            else if (ev_dn) num_q <= (num_q == 7'h0) ? 7'h63 : num_q - 7'h1;
        end
    end

    assign num_tens = 4'(num_q / 7'hA);
    assign num_ones = 4'(num_q % 7'hA);

    // Editing
    assign flip = 32'h0 - edit_q;
    assign flip_ok = !($signed(flip) < $signed(par_min)) && !($signed(flip) > $signed(par_max));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            edit_q <= 32'h0;
            cur_q <= 3'h0;
        end else if (st_q == ST_PAR && st_d == ST_EDIT) begin
            edit_q <= par_value;
            cur_q <= 3'h0;
        end else if (st_q == ST_EDIT && st_d == ST_EDIT) begin
            if (ev_up) edit_q <= edit_q + fpk_pow10(cur_q);
            else if (ev_dn) edit_q <= edit_q - fpk_pow10(cur_q);
            else if (ev_shift) cur_q <= (cur_q == CUR_LAST) ? 3'h0 : cur_q + 3'h1;
            else if (ev_long && flip_ok) edit_q <= flip;
        end
    end

    // Number source for the decimal converter
    assign src = (st_q == ST_EDIT || st_q == ST_STAT) ? edit_q :
        mon_wide ? mon_value : {{16{mon_value[15]}}, mon_value[15:0]};
    assign neg = src[31];
    assign mag = neg ? (32'h0 - src) : src;
    assign cv.start = !cv.busy;
    assign cv.bin = mag;

    // Display composition, digit 4 leftmost
    assign hw = half_q ? mon_value[31:16] : mon_value[15:0];
    assign tag_g = {G_N, G_DASH, G_BLANK, fpk_hex({3'h0, mon_sel_q[4]}), fpk_hex(mon_sel_q[3:0])};
    assign mon_hex_g = {mon_wide ? (half_q ? G_H : G_L) : G_BLANK,
        fpk_hex(hw[15:12]), fpk_hex(hw[11:8]), fpk_hex(hw[7:4]), fpk_hex(hw[3:0])};
    assign mon_dec_g = fpk_bcd5((mon_wide && half_q) ? cv.bcd[39:20] : cv.bcd[19:0]);
    assign par_g = {G_P, fpk_hex(grp_q), G_DASH, fpk_hex(num_tens), fpk_hex(num_ones)};
    assign alm_g = {ALARM_PREFIX_GLYPHS, fpk_hex(alarm_code[11:8]),
        fpk_hex(alarm_code[7:4]), fpk_hex(alarm_code[3:0])};
    assign stat_g = (stat_q == SV_RDONLY) ? TXT_RDONLY :
        (stat_q == SV_LOCKED) ? TXT_LOCKED :
        (stat_q == SV_RANGE) ? TXT_RANGE :
        (stat_q == SV_SRVON) ? TXT_SRVON :
        (stat_q == SV_PWRON) ? TXT_PWRON : TXT_SAVED;
    assign disp_g = (st_q == ST_BOOT || (st_q == ST_MON && show_on)) ? tag_g :
        (st_q == ST_MON) ? (hex_q ? mon_hex_g : mon_dec_g) :
        (st_q == ST_PAR) ? par_g :
        (st_q == ST_EDIT) ? fpk_bcd5(cv.bcd[19:0]) :
        (st_q == ST_STAT) ? stat_g : alm_g;

    assign dec_show = (st_q == ST_MON && !hex_q && !show_on) || st_q == ST_EDIT;
    assign wide_dec = st_q == ST_MON && !hex_q && !show_on && mon_wide;
    assign dp_d = {(dec_show && neg) ? 2'b11 : 2'b00, 1'b0,
        wide_dec ? {!half_q, half_q} : 2'b00};
    assign blink_d = (st_q == ST_EDIT) ? (5'h1 << cur_q) : 5'h0;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seg_q <= 35'h0;
            dp_q <= 5'h0;
            blink_q <= 5'h0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                seg_q[i*7+:7] <= fpk_seg(disp_g[i*5+:5]);
            end
            dp_q <= dp_d;
            blink_q <= blink_d;
        end
    end

    assign mon_sel = mon_sel_q;
    assign grp_sel = grp_q;
    assign par_num = num_q;
    assign par_wr_en = par_wr_en_q;
    assign par_wr_value = par_wr_value_q;
    assign cmd_exec = cmd_exec_q;
    assign seg_out = seg_q;
    assign dp_out = dp_q;
    assign blink_out = blink_q;
    assign ui_mode = st_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    AST_BOOT_EXIT: assert property (
        (st_q == ST_BOOT && show_end) |=> st_q == ST_MON)
        else $error("boot display did not end in monitor mode");

    AST_MODE_SKIP: assert property (
        (st_q == ST_MON && ev_mode && !alarm_active && !alarm_new && !idle_hit) |=> st_q == ST_PAR)
        else $error("mode key did not skip absent alarm mode");

    AST_NEW_ALARM: assert property (
        (st_q != ST_BOOT && alarm_new) |=> st_q == ST_ALM)
        else $error("new alarm did not force alarm display");

    AST_IDLE: assert property (
        idle_hit |=> (st_q == ST_ALM) ##1 (idle_q == 16'h0))
        else $error("idle timeout did not return to alarm mode");

    AST_EDIT_ABORT: assert property (
        (st_q == ST_EDIT && ev_mode && !alarm_new && !idle_hit) |=> (st_q == ST_PAR) ##1 !par_wr_en_q)
        else $error("aborted edit saved or stayed");

    AST_RDONLY: assert property (
        (st_q == ST_EDIT && ev_set && par_ro && !ev_mode && !alarm_new && !idle_hit) |=>
            (stat_q == SV_RDONLY) && !par_wr_en_q && !cmd_exec_q)
        else $error("read-only save not refused");

    AST_PWRON: assert property (
        (commit && accept && par_restart && !par_is_cmd) |=> par_wr_en_q && stat_q == SV_PWRON)
        else $error("restart parameter not stored with power-on code");

    AST_STAT_HOLD: assert property (
        (st_q == ST_EDIT && st_d == ST_STAT) |=> (st_q == ST_STAT) && (show_q == 16'(SHOW_T)))
        else $error("result code hold not started");

    AST_SIGN: assert property (
        (st_q == ST_EDIT && st_d == ST_EDIT && ev_long && flip_ok && !ev_up && !ev_dn && !ev_shift)
            |=> edit_q == 32'h0 - $past(edit_q))
        else $error("long shift did not toggle sign");

    AST_HEX_NOSIGN: assert property (
        (st_q == ST_MON && hex_q && !show_on) |=> dp_q[4:3] == 2'b00)
        else $error("hex display shows a sign");

    AST_HALF_DP: assert property (
        wide_dec |=> dp_q[1:0] == ($past(half_q) ? 2'b01 : 2'b10))
        else $error("half indication wrong");
endmodule
`default_nettype wire

/* test/fpk_operator.sv */
`timescale 1ns/1ps
`default_nettype none
module fpk_operator #(
    parameter int TICK_CYC = 4
) (
    input wire logic mclk,
    input wire logic go,
    input wire logic [2:0] key_idx,
    input wire logic [7:0] ticks,
    output logic busy,
    output logic [4:0] key_raw
);
    int cnt = 0;
    int tot = 0;
    logic [2:0] k_q = 3'h0;
    initial busy = 1'b0;
    initial key_raw = 5'h00;
    // Contacts chatter at press start; release lasts three ticks
    always @(posedge mclk) begin
        if (go && !busy) begin
            tot <= (ticks + 3) * TICK_CYC;
            cnt <= (ticks + 3) * TICK_CYC;
            k_q <= key_idx;
            busy <= 1'b1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            busy <= cnt > 1;
            key_raw <= (cnt > 3 * TICK_CYC && !(cnt > tot - 3 && cnt[0])) ? 5'h01 << k_q : 5'h00;
        end
    end
endmodule
`default_nettype wire

/* test/fpk_panel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fpk_panel_tb;
    import fpk_pkg::*;
    localparam int TC = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0;
    logic [2:0] key_idx = 3'h0;
    logic [7:0] ticks = 8'h00;
    logic busy;
    logic [4:0] key_raw;
    logic alarm_active = 1'b0;
    logic alarm_new = 1'b0;
    logic [11:0] alarm_code = 12'h000;
    logic [31:0] par_value = 32'h00000005;
    logic [4:0] flags = 5'h00;
    logic [31:0] mon_value = 32'h000004D2;
    logic mon_wide = 1'b0;
    logic par_is_cmd = 1'b0;
    int n_cmd = 0;
    logic [4:0] mon_sel, dp_out, blink_out;
    logic [3:0] grp_sel;
    logic [6:0] par_num;
    logic par_wr_en, cmd_exec;
    logic [31:0] par_wr_value;
    logic [34:0] seg_out;
    logic [2:0] ui_mode;
    int n_fail = 0;
    int compares = 0;
    int n_wr = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (par_wr_en === 1'b1) n_wr <= n_wr + 1;
    always @(posedge mclk) if (cmd_exec === 1'b1) n_cmd <= n_cmd + 1;
    fpk_operator #(.TICK_CYC(TC)) op (.mclk(mclk), .go(go), .key_idx(key_idx), .ticks(ticks), .busy(busy),
        .key_raw(key_raw));
    fpk_panel #(.TICK_CYC(TC), .SHOW_T(12), .IDLE_T(20), .HOLD_T(6)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .key_raw(key_raw), .alarm_active(alarm_active), .alarm_new(alarm_new), .alarm_code(alarm_code),
        .mon_value(mon_value), .mon_wide(mon_wide), .par_value(par_value), .par_min(32'hFFFFFF9C),
        .par_max(32'h00000064), .par_ro(flags[0]), .par_locked(flags[1]), .par_reserved(flags[3]),
        .par_restart(flags[4]), .par_is_cmd(par_is_cmd), .servo_on(flags[2]), .mon_sel(mon_sel), .grp_sel(grp_sel),
        .par_num(par_num), .par_wr_en(par_wr_en), .par_wr_value(par_wr_value), .cmd_exec(cmd_exec),
        .seg_out(seg_out), .dp_out(dp_out), .blink_out(blink_out), .ui_mode(ui_mode));
    task automatic give_verdict();
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int i;
        for (i = 0; i < lim && ui_mode !== m; i++) @(posedge mclk);
        chk("ui_mode", 35'(m), 35'(ui_mode));
        if (ui_mode !== m) give_verdict();
    endtask
    task automatic press(input int k, input int t);
        int i;
        @(posedge mclk);
        go <= 1'b1;
        key_idx <= 3'(k);
        ticks <= 8'(t);
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        for (i = 0; i < 300 && busy === 1'b1; i++) @(posedge mclk);
        chk("operator", 35'(0), 35'(busy));
        if (busy !== 1'b0) give_verdict();
    endtask
    task automatic sc_boot();
        repeat (6 * TC) @(posedge mclk);
        chk("boot", 35'(0), 35'(ui_mode));
        wait_mode(3'h1, 10 * TC);
    endtask
    task automatic sc_menu();
        press(K_UP, 4);
        chk("mon_up", 35'(1), 35'(mon_sel));
        press(K_DOWN, 4);
        chk("mon_down", 35'(0), 35'(mon_sel));
        press(K_MODE, 4);
        wait_mode(3'h3, 10);
        press(K_SHIFT, 3);
        chk("grp", 35'(1), 35'(grp_sel));
        press(K_UP, 4);
        chk("num", 35'(1), 35'(par_num));
        press(K_SET, 4);
        wait_mode(3'h2, 10);
        press(K_MODE, 4);
        wait_mode(3'h3, 10);
        chk("no_store", 35'(0), 35'(n_wr));
    endtask
    task automatic sc_save();
        int i;
        int exp_wr;
        logic [13:0] code_g [6] = '{14'h2840, 14'h1C5C, 14'h36D0, 14'h2877, 14'h39DC, 14'h36F7};
        for (i = 0; i < 6; i++) begin
            exp_wr = n_wr + ((i >= 4) ? 1 : 0);
            flags <= (i < 5) ? 5'h01 << i : 5'h00;
            press(K_SET, 4);
            wait_mode(3'h2, 10);
            press(K_UP, 4);
            chk("cursor", 35'(1), 35'(blink_out));
            press(K_SET, 4);
            wait_mode(3'h6, 20);
            chk("code", 35'(code_g[i]), 35'(seg_out[34:21]));
            chk("stores", 35'(exp_wr), 35'(n_wr));
            if (i >= 4) chk("value", 35'(6), 35'(par_wr_value));
            wait_mode(3'h3, 16 * TC);
        end
        flags <= 5'h00;
    endtask
    task automatic sc_cmd();
        int wr0;
        wr0 = n_wr;
        par_is_cmd <= 1'b1;
        press(K_SET, 4);
        wait_mode(3'h2, 10);
        press(K_SHIFT, 3);
        chk("cursor_left", 35'h2, 35'(blink_out));
        press(K_UP, 4);
        press(K_SHIFT, 10);
        chk("neg_dp", 35'h18, 35'(dp_out));
        press(K_SET, 4);
        chk("cmd", 35'(1), 35'(n_cmd));
        chk("cmd_no_store", 35'(wr0), 35'(n_wr));
        chk("signed", 35'(32'hFFFFFFF1), 35'(par_wr_value));
        wait_mode(3'h3, 16 * TC);
        par_is_cmd <= 1'b0;
    endtask
    task automatic sc_mon();
        mon_wide <= 1'b1;
        mon_value <= 32'hFFFFFB2E;
        press(K_MODE, 4);
        wait_mode(3'h1, 10);
        chk("dp_dec_lo", 35'h1A, 35'(dp_out));
        press(K_SHIFT, 3);
        chk("dp_dec_hi", 35'h19, 35'(dp_out));
        press(K_SET, 4);
        chk("hex_lead", 35'h74, 35'(seg_out[34:28]));
        chk("dp_hex", 35'h00, 35'(dp_out));
        mon_wide <= 1'b0;
    endtask
    task automatic sc_alarm();
        alarm_active <= 1'b1;
        alarm_code <= 12'h3A5;
        alarm_new <= 1'b1;
        @(posedge mclk);
        alarm_new <= 1'b0;
        wait_mode(3'h7, 4);
        repeat (3) @(posedge mclk);
        chk("prefix", {7'h77, 7'h38}, 35'(seg_out[34:21]));
        press(K_MODE, 4);
        wait_mode(3'h3, 10);
        repeat (10 * TC) @(posedge mclk);
        chk("idle_early", 35'(3), 35'(ui_mode));
        wait_mode(3'h7, 16 * TC);
        press(K_MODE, 4);
        wait_mode(3'h3, 10);
        press(K_MODE, 4);
        wait_mode(3'h1, 10);
        press(K_MODE, 4);
        wait_mode(3'h7, 10);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        sc_boot();
        sc_menu();
        sc_save();
        sc_cmd();
        sc_mon();
        sc_alarm();
        give_verdict();
    end
endmodule
`default_nettype wire
